// [bench/core_fetch_model.sv]
`timescale 1ns/1ps
// ********************************
// core stand-in: fetch pointer
// ********************************
module core_fetch_model (
    // clock, reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // redirect from the unit
    input wire logic redirect_in,
    input wire logic [31:0] vector_in,
    // fetch pointer
    output logic [31:0] pc_out
);
    logic [31:0] pc_reg;
    logic [31:0] pc_next;
    // sequential fetch unless redirected, so pc always moves
    always_comb begin
        pc_next = redirect_in ? vector_in : pc_reg + 32'h4;
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pc_reg <= 32'h0;
        end else begin
            pc_reg <= pc_next;
        end
    end
    assign pc_out = pc_reg;
endmodule

// [bench/vectored_exception_unit_properties.sv]
`timescale 1ns/1ps
// ********************************
// vector, priority and timing checks
// ********************************
module vectored_exception_unit_properties
    import exc_pkg::*;
(
    // clock, reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // event sources
    input wire logic sw_reset_in,
    input wire logic fetch_valid_in,
    input wire logic illegal_insn_in,
    input wire logic syscall_insn_in,
    input wire logic trap_insn_in,
    input wire logic tick_expired_in,
    input wire logic irq_enable_in,
    // load/store
    input wire logic ls_valid_in,
    input wire logic [31:0] ls_addr_in,
    input wire logic [1:0] ls_size_in,
    input wire logic ls_unmapped_in,
    input wire logic ls_periph_in,
    input wire logic ls_stall_out,
    input wire logic ls_done_out,
    // results
    input wire logic supervisor_out,
    input wire logic redirect_out,
    input wire logic [31:0] vector_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic mis = (ls_size_in == SIZE_HALF && ls_addr_in[0]) ||
        (ls_size_in == SIZE_WORD && ls_addr_in[1:0] != 2'h0);
    wire logic ls_hi = sw_reset_in || ls_valid_in;
    wire logic any_ins = fetch_valid_in && (illegal_insn_in || syscall_insn_in || trap_insn_in);
    sequence s_go(logic [31:0] v);
        redirect_out && vector_out == v;
    endsequence
    // c0 and c1 stalled, c2 done
    sequence s_access;
        ls_stall_out ##1 ls_stall_out ##1 (ls_done_out && !ls_stall_out);
    endsequence
    reset_vec_a: assert property (sw_reset_in |=> s_go(VEC_RESET))
        else $error("reset vector wrong");
    bus_err_a: assert property (!sw_reset_in && ls_valid_in && ls_unmapped_in && !mis
        |=> s_go(VEC_BUS_ERROR)) else $error("bus error vector wrong");
    align_vec_a: assert property (!sw_reset_in && ls_valid_in && mis
        |=> s_go(VEC_ALIGN)) else $error("alignment vector wrong");
    illegal_vec_a: assert property (!ls_hi && fetch_valid_in && illegal_insn_in
        |=> s_go(VEC_ILLEGAL)) else $error("illegal vector wrong");
    syscall_vec_a: assert property (!ls_hi && fetch_valid_in && syscall_insn_in
        && !illegal_insn_in |=> s_go(VEC_SYSCALL)) else $error("syscall vector wrong");
    trap_vec_a: assert property (!ls_hi && fetch_valid_in && trap_insn_in && !illegal_insn_in
        && !syscall_insn_in |=> s_go(VEC_TRAP)) else $error("trap vector wrong");
    tick_vec_a: assert property (!ls_hi && !any_ins && irq_enable_in && tick_expired_in
        |=> s_go(VEC_TICK)) else $error("tick vector wrong");
    quiet_core_a: assert property (!ls_hi && !any_ins && !irq_enable_in && $past(rst_n_in)
        |=> !redirect_out) else $error("redirect without a source");
    super_mode_a: assert property (redirect_out |-> supervisor_out)
        else $error("handler not in supervisor mode");
    periph_time_a: assert property (ls_valid_in && !$past(ls_valid_in) && ls_periph_in
        && !ls_unmapped_in && !mis && !sw_reset_in |-> s_access)
        else $error("peripheral access not three cycles");
endmodule

// [bench/vectored_exception_unit_test.sv]
`timescale 1ns/1ps
module vectored_exception_unit_test;
    import exc_pkg::*;
    logic clk_in, rst_n_in, ce_in, sw_reset_in, fetch_valid_in, illegal_insn_in;
    logic syscall_insn_in, trap_insn_in, ls_valid_in, ls_unmapped_in, ls_periph_in;
    logic user_mode_in, tick_expired_in, irq_enable_in, mask_we_in, sleep_in;
    logic wake_timer_irq_in, comparator_irq_in, wake_timer_en_in, comparator_en_in;
    logic ls_stall_out, ls_done_out, supervisor_out, redirect_out, wake_out;
    logic [1:0] ls_size_in;
    logic [31:0] ls_addr_in, vector_out, epc_out, pc_in, pc_seen;
    logic [IRQ_W-1:0] periph_irq_in, mask_in, gp_pin_irq_in;
    int fails = 0;
    int total_checks = 0;
    vectored_exception_unit i_vectored_exception_unit (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .ce_in(ce_in), .sw_reset_in(sw_reset_in), .fetch_valid_in(fetch_valid_in),
        .illegal_insn_in(illegal_insn_in), .syscall_insn_in(syscall_insn_in),
        .trap_insn_in(trap_insn_in), .ls_valid_in(ls_valid_in), .ls_addr_in(ls_addr_in),
        .ls_size_in(ls_size_in), .ls_unmapped_in(ls_unmapped_in),
        .ls_periph_in(ls_periph_in), .ls_stall_out(ls_stall_out),
        .ls_done_out(ls_done_out), .user_mode_in(user_mode_in),
        .supervisor_out(supervisor_out), .redirect_out(redirect_out),
        .vector_out(vector_out), .epc_out(epc_out), .pc_in(pc_in),
        .tick_expired_in(tick_expired_in), .irq_enable_in(irq_enable_in),
        .periph_irq_in(periph_irq_in), .mask_we_in(mask_we_in), .mask_in(mask_in),
        .sleep_in(sleep_in), .gp_pin_irq_in(gp_pin_irq_in),
        .wake_timer_irq_in(wake_timer_irq_in), .comparator_irq_in(comparator_irq_in),
        .wake_timer_en_in(wake_timer_en_in), .comparator_en_in(comparator_en_in),
        .wake_out(wake_out));
    core_fetch_model i_core_fetch_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .redirect_in(redirect_out), .vector_in(vector_out), .pc_out(pc_in));
    // ********************************
    // shared helpers
    // ********************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic quiet;
        {sw_reset_in, fetch_valid_in, illegal_insn_in, syscall_insn_in} <= 4'h0;
        {trap_insn_in, ls_valid_in, ls_unmapped_in, ls_periph_in} <= 4'h0;
        {tick_expired_in, wake_timer_irq_in, comparator_irq_in} <= 3'h0;
        {periph_irq_in, gp_pin_irq_in} <= 32'h0;
    endtask
    // sources set at this edge are taken at the next one
    task automatic hit(input logic [31:0] e, input logic r);
        #1 pc_seen = pc_in;
        @(posedge clk_in);
        quiet;
        #1 chk("redirect", {31'h0, r}, redirect_out);
        if (r) chk("vector", e, vector_out);
        if (r) chk("supervisor", 32'h1, supervisor_out);
        if (r && e !== VEC_RESET) chk("epc", pc_seen, epc_out);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ********************************
    // scenarios
    // ********************************
    task automatic t_reset;
        repeat (2) begin
            @(posedge clk_in);
            #1 chk("reset vector", VEC_RESET, vector_out);
            chk("reset redirect", 32'h1, redirect_out);
            @(posedge clk_in);
            rst_n_in <= 1'b0;
            @(posedge clk_in);
            rst_n_in <= 1'b1;
        end
    endtask
    task automatic t_insn;
        logic [2:0] sel[5] = '{3'h4, 3'h2, 3'h1, 3'h7, 3'h3};
        logic [31:0] v[5] = '{VEC_ILLEGAL, VEC_SYSCALL, VEC_TRAP, VEC_ILLEGAL, VEC_SYSCALL};
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_in);
            fetch_valid_in <= 1'b1;
            {illegal_insn_in, syscall_insn_in, trap_insn_in} <= sel[i];
            hit(v[i], 1'b1);
        end
        @(posedge clk_in);
        {illegal_insn_in, syscall_insn_in, trap_insn_in} <= 3'h7;
        hit(32'h0, 1'b0);
        @(posedge clk_in);
        {sw_reset_in, fetch_valid_in, syscall_insn_in, ls_valid_in} <= 4'hF;
        hit(VEC_RESET, 1'b1);
    endtask
    task automatic t_ls;
        logic [1:0] sz[6] = '{SIZE_HALF, SIZE_WORD, SIZE_WORD, SIZE_HALF, SIZE_BYTE, SIZE_WORD};
        logic [1:0] lo[6] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h1, 2'h0};
        logic [5:0] um = 6'h1C;
        logic [31:0] v[6] = '{VEC_ALIGN, VEC_ALIGN, VEC_ALIGN, VEC_BUS_ERROR, VEC_BUS_ERROR,
            VEC_ILLEGAL};
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_in);
            {fetch_valid_in, illegal_insn_in, ls_valid_in} <= 3'h7;
            ls_size_in <= sz[i];
            ls_addr_in <= {30'h00003FFC, lo[i]};
            ls_unmapped_in <= um[i];
            hit(v[i], 1'b1);
        end
    endtask
    task automatic t_periph;
        @(posedge clk_in);
        {ls_valid_in, ls_periph_in} <= 2'h3;
        ls_size_in <= SIZE_WORD;
        ls_addr_in <= 32'h0000FFF4;
        #1 chk("stall c0", 32'h1, ls_stall_out);
        @(posedge clk_in);
        #1 chk("done c1", 32'h0, ls_done_out);
        @(posedge clk_in);
        #1 chk("done c2", 32'h1, ls_done_out);
        chk("stall c2", 32'h0, ls_stall_out);
        @(posedge clk_in);
        quiet;
    endtask
    task automatic t_irq;
        @(posedge clk_in);
        {tick_expired_in, periph_irq_in} <= {1'b1, 16'hFFFF};
        hit(32'h0, 1'b0);
        @(posedge clk_in);
        {irq_enable_in, periph_irq_in} <= {1'b1, 16'h0008};
        hit(32'h0, 1'b0);
        @(posedge clk_in);
        {mask_we_in, mask_in} <= {1'b1, 16'h0008};
        @(posedge clk_in);
        {mask_we_in, periph_irq_in} <= {1'b0, 16'h0010};
        hit(32'h0, 1'b0);
        @(posedge clk_in);
        periph_irq_in <= 16'h0008;
        hit(VEC_HW_IRQ, 1'b1);
        @(posedge clk_in);
        gp_pin_irq_in <= 16'h0008;
        hit(VEC_HW_IRQ, 1'b1);
        @(posedge clk_in);
        {tick_expired_in, periph_irq_in} <= {1'b1, 16'h0008};
        hit(VEC_TICK, 1'b1);
    endtask
    task automatic t_sleep;
        logic [4:0] row[5] = '{5'h10, 5'h08, 5'h0C, 5'h02, 5'h03};
        logic [4:0] ex = 5'h15;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_in);
            {irq_enable_in, sleep_in} <= 2'h1;
            gp_pin_irq_in <= {7'h00, row[i][4], 8'h00};
            {wake_timer_irq_in, wake_timer_en_in} <= row[i][3:2];
            {comparator_irq_in, comparator_en_in} <= row[i][1:0];
            hit(32'h0, 1'b0);
            chk("wake", {31'h0, ex[i]}, wake_out);
        end
    endtask
    // ********************************
    // clock, watchdog, main sequence
    // ********************************
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        #5000;
        fails++;
        wrap_up;
    end
    initial begin
        {rst_n_in, ce_in, user_mode_in, irq_enable_in, mask_we_in, sleep_in} = 6'h18;
        {wake_timer_en_in, comparator_en_in, ls_size_in, ls_addr_in, mask_in} = '0;
        quiet;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset;
        t_insn;
        t_ls;
        t_periph;
        t_irq;
        t_sleep;
        wrap_up;
    end
endmodule
bind vectored_exception_unit vectored_exception_unit_properties
    i_vectored_exception_unit_properties (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sw_reset_in(sw_reset_in), .fetch_valid_in(fetch_valid_in),
    .illegal_insn_in(illegal_insn_in), .syscall_insn_in(syscall_insn_in),
    .trap_insn_in(trap_insn_in), .tick_expired_in(tick_expired_in),
    .irq_enable_in(irq_enable_in), .ls_valid_in(ls_valid_in), .ls_addr_in(ls_addr_in),
    .ls_size_in(ls_size_in), .ls_unmapped_in(ls_unmapped_in), .ls_periph_in(ls_periph_in),
    .ls_stall_out(ls_stall_out), .ls_done_out(ls_done_out),
    .supervisor_out(supervisor_out), .redirect_out(redirect_out),
    .vector_out(vector_out));

// [rtl/exc_pkg.sv]
package exc_pkg;
    // ***********************************
    // vector addresses
    // ***********************************
    localparam logic [31:0] VEC_RESET = 32'h0000_0100;
    localparam logic [31:0] VEC_BUS_ERROR = 32'h0000_0200;
    localparam logic [31:0] VEC_TICK = 32'h0000_0500;
    localparam logic [31:0] VEC_ALIGN = 32'h0000_0600;
    localparam logic [31:0] VEC_ILLEGAL = 32'h0000_0700;
    localparam logic [31:0] VEC_HW_IRQ = 32'h0000_0800;
    localparam logic [31:0] VEC_SYSCALL = 32'h0000_0C00;
    localparam logic [31:0] VEC_TRAP = 32'h0000_0E00;

    // ***********************************
    // widths and timing
    // ***********************************
    localparam int IRQ_W = 16;
    localparam logic [IRQ_W-1:0] MASK_RESET = 16'h0000;
    localparam int PERIPH_ACCESS_NS = 15;
    localparam int CLK_PERIOD_PS = 5000;
    // least time, rounded up to whole cycles
    localparam int PERIPH_CYCLES_INT = (PERIPH_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [1:0] PERIPH_CYCLES = 2'(PERIPH_CYCLES_INT);

    // access sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } acc_state_t;

    // true when the access is not naturally aligned for its size
    function automatic logic misaligned(input logic [1:0] size, input logic [1:0] addr_lo);
        misaligned = ((size == SIZE_HALF) && addr_lo[0]) ||
                     ((size == SIZE_WORD) && (addr_lo != 2'h0));
    endfunction
endpackage

// [rtl/periph_access_timer.sv]
`timescale 1ns/1ps
module periph_access_timer
    import exc_pkg::*;
(
    // clock, reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // access
    input wire logic start_in,
    input wire logic abort_in,
    output logic busy_out,
    output logic done_out
);
    acc_state_t state_reg;
    acc_state_t state_next;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (start_in && !abort_in) begin
                    state_next = ST_WAIT;
                    // the start cycle already counts as the first of the access
                    cnt_next = PERIPH_CYCLES - 2'h2;
                end
            end
            ST_WAIT: begin
                if (abort_in) begin
                    state_next = ST_IDLE;
                end else if (cnt_reg == 2'h1) begin
                    state_next = ST_DONE; // RQ13
                end else begin
                    cnt_next = cnt_reg - 2'h1;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 2'h0;
        end else if (ce_in) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // access spans cycles 0,1 busy and done on cycle 2: three cycles total
    assign busy_out = (state_reg == ST_WAIT) || (start_in && state_reg == ST_IDLE);
    assign done_out = (state_reg == ST_DONE);
endmodule

// [rtl/peripheral_interrupt_masker.sv]
`timescale 1ns/1ps
module peripheral_interrupt_masker
    import exc_pkg::*;
(
    // clock, reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // power and mask load
    input wire logic powered_in,
    input wire logic mask_we_in,
    input wire logic [IRQ_W-1:0] mask_in,
    // requests
    input wire logic [IRQ_W-1:0] irq_in,
    output logic irq_out
);
    logic [IRQ_W-1:0] mask_reg;
    logic [IRQ_W-1:0] mask_next;

    always_comb begin
        mask_next = mask_reg;
        if (mask_we_in && powered_in) begin
            mask_next = mask_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask_reg <= MASK_RESET;
        end else if (ce_in) begin
            mask_reg <= mask_next;
        end
    end

    // unpowered in sleep: passes nothing
    assign irq_out = powered_in && |(irq_in & mask_reg); // RQ11 RQ12
endmodule

// [rtl/vectored_exception_unit.sv]
`timescale 1ns/1ps
// What this block does
// RQ1 - taken event abandons flow, loads vector into pc; handler starts next cycle
// RQ2 - every handler runs in supervisor mode
// RQ3 - any reset, software or hardware, starts execution at 0x100
// RQ4 - access to unpopulated address raises bus error at 0x200
// RQ5 - tick timer expiry goes to 0x500, enabled hardware interrupts to 0x800
// RQ6 - misaligned load or store raises alignment exception at 0x600
// RQ7 - halfword at odd address, word not multiple of four, is misaligned
// RQ8 - unrecognised fetched instruction raises illegal instruction at 0x700
// RQ9 - system call instruction vectors to 0xC00
// RQ10 - trap instruction vectors to 0xE00
// RQ11 - each hardware interrupt request passes an individual mask first
// RQ12 - in sleep masker may be off; pin interrupts and chosen wakers wake
// RQ13 - peripheral register accesses take three clock cycles
// RQ14 - priority: reset, then instruction exceptions, then tick and hardware
module vectored_exception_unit
    import exc_pkg::*;
(
    // clock, reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // software reset request
    input wire logic sw_reset_in,
    // instruction stream
    input wire logic fetch_valid_in,
    input wire logic illegal_insn_in,
    input wire logic syscall_insn_in,
    input wire logic trap_insn_in,
    // load/store path
    input wire logic ls_valid_in,
    input wire logic [31:0] ls_addr_in,
    input wire logic [1:0] ls_size_in,
    input wire logic ls_unmapped_in,
    input wire logic ls_periph_in,
    output logic ls_stall_out,
    output logic ls_done_out,
    // privilege
    input wire logic user_mode_in,
    output logic supervisor_out,
    // redirect to core
    output logic redirect_out,
    output logic [31:0] vector_out,
    output logic [31:0] epc_out,
    input wire logic [31:0] pc_in,
    // interrupts
    input wire logic tick_expired_in,
    input wire logic irq_enable_in,
    input wire logic [IRQ_W-1:0] periph_irq_in,
    input wire logic mask_we_in,
    input wire logic [IRQ_W-1:0] mask_in,
    // sleep and wake
    input wire logic sleep_in,
    input wire logic [IRQ_W-1:0] gp_pin_irq_in,
    input wire logic wake_timer_irq_in,
    input wire logic comparator_irq_in,
    input wire logic wake_timer_en_in,
    input wire logic comparator_en_in,
    output logic wake_out
);
    // ***********************************
    // helper functions
    // ***********************************
    // instruction flags mean nothing without a valid fetch behind them
    function automatic logic insn_flag(input logic valid, input logic flag);
        insn_flag = valid && flag;
    endfunction

    // a sleep waker counts only when chosen to stay live
    function automatic logic waker(input logic enable, input logic irq);
        waker = enable && irq;
    endfunction

    // ***********************************
    // masking
    // ***********************************
    logic hw_irq;
    logic [IRQ_W-1:0] all_irq;
    logic masker_powered;

    assign all_irq = periph_irq_in | gp_pin_irq_in;
    // the masker loses power in sleep, so it can neither mask nor wake
    assign masker_powered = !sleep_in;

    peripheral_interrupt_masker i_peripheral_interrupt_masker (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .powered_in(masker_powered),
        .mask_we_in(mask_we_in),
        .mask_in(mask_in),
        .irq_in(all_irq),
        .irq_out(hw_irq)
    );

    // ***********************************
    // sleep wake, kept off the masker
    // ***********************************
    logic wake_reg;
    logic wake_next;
    logic any_pin;
    logic timer_wake;
    logic comparator_wake;

    assign any_pin = |gp_pin_irq_in;
    assign timer_wake = waker(wake_timer_en_in, wake_timer_irq_in); // RQ12
    assign comparator_wake = waker(comparator_en_in, comparator_irq_in); // RQ12

    // registered so a short glitch on a waker never reaches the power logic
    always_comb begin
        wake_next = sleep_in && (any_pin || timer_wake || comparator_wake); // RQ12
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake_reg <= 1'b0;
        end else if (ce_in) begin
            wake_reg <= wake_next;
        end
    end

    // ***********************************
    // load/store checks and peripheral access timing
    // ***********************************
    logic take;
    logic misalign;
    logic bus_err;
    logic periph_go;
    logic periph_busy;
    logic periph_done;

    assign misalign = ls_valid_in && misaligned(ls_size_in, ls_addr_in[1:0]); // RQ6 RQ7
    assign bus_err = ls_valid_in && ls_unmapped_in && !misalign; // RQ4
    // a faulting access never opens the peripheral window
    assign periph_go = ls_valid_in && ls_periph_in && !misalign && !ls_unmapped_in;

    // a take aborts the window; the core repeats the access after the handler
    periph_access_timer i_periph_access_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .start_in(periph_go),
        .abort_in(take),
        .busy_out(periph_busy),
        .done_out(periph_done)
    );

    // core holds the access while the three-cycle window runs
    assign ls_stall_out = periph_busy && !periph_done; // RQ13
    assign ls_done_out = periph_done;

    // ***********************************
    // qualified event sources
    // ***********************************
    logic pending_reset_reg;
    logic reset_src;
    logic illegal_src;
    logic syscall_src;
    logic trap_src;
    logic tick_src;
    logic hw_src;

    assign reset_src = pending_reset_reg || sw_reset_in; // RQ3
    assign illegal_src = insn_flag(fetch_valid_in, illegal_insn_in); // RQ8
    assign syscall_src = insn_flag(fetch_valid_in, syscall_insn_in); // RQ9
    assign trap_src = insn_flag(fetch_valid_in, trap_insn_in); // RQ10
    // tick and hardware are refused while the global enable is low
    assign tick_src = tick_expired_in && irq_enable_in; // RQ5
    // pin requests share the masked line with the peripherals when awake
    assign hw_src = hw_irq && irq_enable_in; // RQ5 RQ11

    // ***********************************
    // priority and vector select
    // ***********************************
    logic [31:0] vec_sel;

    always_comb begin
        take = 1'b1;
        vec_sel = VEC_RESET;
        // reset first, then instruction exceptions, then async sources
        if (reset_src) begin
            vec_sel = VEC_RESET; // RQ3 RQ14
        end else if (bus_err) begin
            vec_sel = VEC_BUS_ERROR; // RQ4 RQ14
        end else if (misalign) begin
            vec_sel = VEC_ALIGN; // RQ6
        end else if (illegal_src) begin
            vec_sel = VEC_ILLEGAL; // RQ8
        end else if (syscall_src) begin
            vec_sel = VEC_SYSCALL; // RQ9
        end else if (trap_src) begin
            vec_sel = VEC_TRAP; // RQ10
        end else if (tick_src) begin
            vec_sel = VEC_TICK; // RQ5 RQ14
        end else if (hw_src) begin
            vec_sel = VEC_HW_IRQ; // RQ5
        end else begin
            take = 1'b0;
        end
    end

    // ***********************************
    // reset entry
    // ***********************************
    logic pending_reset_next;

    // cleared by the first enabled edge, which takes the reset entry
    always_comb begin
        pending_reset_next = 1'b0;
    end

    // reset leaves a pending entry so the first redirect goes to the reset vector
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pending_reset_reg <= 1'b1; // RQ3
        end else if (ce_in) begin
            pending_reset_reg <= pending_reset_next;
        end
    end

    // ***********************************
    // redirect and vector
    // ***********************************
    logic redirect_reg;
    logic redirect_next;
    logic [31:0] vector_reg;
    logic [31:0] vector_next;

    // vector stands until the next entry so the core may read it late
    always_comb begin
        redirect_next = take; // RQ1
        vector_next = vector_reg;
        if (take) begin
            vector_next = vec_sel; // RQ1
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            redirect_reg <= 1'b0;
            vector_reg <= VEC_RESET;
        end else if (ce_in) begin
            redirect_reg <= redirect_next;
            vector_reg <= vector_next;
        end
    end

    // ***********************************
    // return address
    // ***********************************
    logic [31:0] epc_reg;
    logic [31:0] epc_next;

    always_comb begin
        epc_next = epc_reg;
        // a reset entry has no flow to return to
        if (take && !reset_src) begin
            epc_next = pc_in; // RQ1
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            epc_reg <= 32'h0000_0000;
        end else if (ce_in) begin
            epc_reg <= epc_next;
        end
    end

    // ***********************************
    // privilege
    // ***********************************
    logic super_reg;
    logic super_next;

    // entry forces supervisor; once the pulse ends, follow the core's mode
    always_comb begin
        super_next = !user_mode_in;
        if (take) begin
            super_next = 1'b1; // RQ2
        end else if (redirect_reg) begin
            super_next = super_reg;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            super_reg <= 1'b1;
        end else if (ce_in) begin
            super_reg <= super_next;
        end
    end

    // ***********************************
    // outputs
    // ***********************************
    assign redirect_out = redirect_reg;
    assign vector_out = vector_reg;
    assign epc_out = epc_reg;
    assign supervisor_out = super_reg;
    assign wake_out = wake_reg;
endmodule
